// ==== hw/ceq_ctrl_regs.sv ====
module ceq_ctrl_regs (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // serial register port pins
    input  wire logic       spiSck,
    input  wire logic       spiSelN,
    input  wire logic       spiMosi,
    output logic            spiMiso,
    // analog front end status
    input  wire logic       carrierDet,
    // equalizer power and path control
    output logic            eqSleepQ,
    output logic            outMuteQ,
    output logic            eqBypassQ,
    output logic            eqLockQ,
    output logic            acqRestartQ,
    // output driver and launch settings
    output logic [1:0]      outSwing,
    output logic [1:0]      outOffset,
    output logic            deEmphEn,
    output logic [1:0]      deEmphLevel,
    output logic            launchAtten
);
    ceq_frame_if frm ();

    logic [3:0] pinLvl;
    logic       muteQ;
    logic       bypassQ;
    logic [1:0] sleepQ;
    logic       rsvQ;
    logic [7:0] drvQ;
    logic [7:0] launchQ;
    ceq_pkg::ceq_acq_t acqStateQ;
    ceq_pkg::ceq_acq_t acqStateD;

    // select idles high so it resets high
    ceq_sync3 #(
        .WIDTH   (4),
        .RST_VAL (4'h2)
    ) u_sync (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .asyncIn   ({carrierDet, spiMosi, spiSelN, spiSck}),
        .stableOut (pinLvl)
    );

    wire carrierLvl = pinLvl[3];

    ceq_spi_shift u_spi (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .sckLvl   (pinLvl[0]),
        .selNLvl  (pinLvl[1]),
        .mosiLvl  (pinLvl[2]),
        .misoQ    (spiMiso),
        .frm      (frm.spi)
    );

    // frame decode
    wire [6:0] frAddr  = frm.frameWord[ceq_pkg::ADDR_HI:ceq_pkg::ADDR_LO];
    wire [7:0] frData  = frm.frameWord[7:0];
    wire       frWrite = frm.frameValid
                && (frm.frameWord[ceq_pkg::CMD_BIT] == ceq_pkg::CMD_WRITE);
    wire wrGen    = frWrite && (frAddr == ceq_pkg::ADDR_GEN);
    wire wrDrv    = frWrite && (frAddr == ceq_pkg::ADDR_DRV);
    wire wrLaunch = frWrite && (frAddr == ceq_pkg::ADDR_LAUNCH);
    wire masterRst = wrGen && frData[ceq_pkg::GEN_MRST_BIT];
    wire acqRst    = wrGen && frData[ceq_pkg::GEN_ARST_BIT];

    // self-clearing bits are never stored, so they read 0
    wire [7:0] genRead = {carrierLvl, muteQ, bypassQ, sleepQ, rsvQ,
                          2'h0};
    assign frm.readData =
        (frAddr == ceq_pkg::ADDR_GEN)    ? genRead :
        (frAddr == ceq_pkg::ADDR_DRV)    ? drvQ    :
        (frAddr == ceq_pkg::ADDR_LAUNCH) ? launchQ : 8'h00;

    // general control: master reset outranks the data of its own write
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            muteQ   <= ceq_pkg::MUTE_RST;
            bypassQ <= ceq_pkg::BYP_RST;
            sleepQ  <= ceq_pkg::SLEEP_RST;
            rsvQ    <= ceq_pkg::RSV_RST;
        end else if (masterRst) begin
            muteQ   <= ceq_pkg::MUTE_RST;
            bypassQ <= ceq_pkg::BYP_RST;
            sleepQ  <= ceq_pkg::SLEEP_RST;
            rsvQ    <= ceq_pkg::RSV_RST;
        end else if (wrGen) begin
            muteQ   <= frData[ceq_pkg::GEN_MUTE_BIT];
            bypassQ <= frData[ceq_pkg::GEN_BYP_BIT];
            sleepQ  <= frData[ceq_pkg::GEN_SLP_HI:ceq_pkg::GEN_SLP_LO];
            rsvQ    <= frData[ceq_pkg::GEN_RSV_BIT];
        end
    end

    // driver bit 0 is read-only zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            drvQ    <= ceq_pkg::DRV_RST;
            launchQ <= ceq_pkg::LAUNCH_RST;
        end else if (masterRst) begin
            drvQ    <= ceq_pkg::DRV_RST;
            launchQ <= ceq_pkg::LAUNCH_RST;
        end else begin
            if (wrDrv) begin
                drvQ <= frData & ceq_pkg::DRV_WR_MASK;
            end
            if (wrLaunch) begin
                launchQ <= frData;
            end
        end
    end

    // driver fields go straight out of the register flops
    assign outSwing    =
        drvQ[ceq_pkg::DRV_SWG_HI:ceq_pkg::DRV_SWG_LO];
    assign outOffset   =
        drvQ[ceq_pkg::DRV_OFS_HI:ceq_pkg::DRV_OFS_LO];
    assign deEmphEn    = drvQ[ceq_pkg::DRV_DEEN_BIT];
    assign deEmphLevel =
        drvQ[ceq_pkg::DRV_DLV_HI:ceq_pkg::DRV_DLV_LO];
    assign launchAtten = launchQ[ceq_pkg::LAUNCH_ATT_BIT];

    // reserved sleep code 11 behaves as always-on
    function automatic logic sleepDecode(input logic [1:0] code,
                                         input logic carrier);
        sleepDecode = (code == ceq_pkg::SLEEP_FORCE)
                      || ((code == ceq_pkg::SLEEP_AUTO) && !carrier);
    endfunction

    wire sleepNow  = sleepDecode(sleepQ, carrierLvl);
    wire muteNow   = !sleepNow && muteQ;
    wire bypassNow = !sleepNow && !muteQ && bypassQ;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            eqSleepQ  <= 1'b0;
            outMuteQ  <= 1'b0;
            eqBypassQ <= 1'b0;
        end else begin
            eqSleepQ  <= sleepNow;
            outMuteQ  <= muteNow;
            eqBypassQ <= bypassNow;
        end
    end

    // acquisition fsm: either reset bit restarts it from search
    always_comb begin
        acqStateD = acqStateQ;
        if (masterRst || acqRst) begin
            acqStateD = ceq_pkg::ACQ_SEEK;
        end else begin
            case (acqStateQ)
                ceq_pkg::ACQ_SLEEP: begin
                    if (!sleepNow) acqStateD = ceq_pkg::ACQ_SEEK;
                end
                ceq_pkg::ACQ_SEEK: begin
                    if (sleepNow) acqStateD = ceq_pkg::ACQ_SLEEP;
                    else if (carrierLvl) acqStateD = ceq_pkg::ACQ_LOCK;
                end
                ceq_pkg::ACQ_LOCK: begin
                    if (sleepNow) acqStateD = ceq_pkg::ACQ_SLEEP;
                    else if (!carrierLvl) acqStateD = ceq_pkg::ACQ_SEEK;
                end
                default: acqStateD = ceq_pkg::ACQ_SEEK;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            acqStateQ   <= ceq_pkg::ACQ_SEEK;
            eqLockQ     <= 1'b0;
            acqRestartQ <= 1'b0;
        end else begin
            acqStateQ   <= acqStateD;
            eqLockQ     <= (acqStateD == ceq_pkg::ACQ_LOCK);
            acqRestartQ <= masterRst || acqRst;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_CD_READBACK:
    assert property ((frAddr == ceq_pkg::ADDR_GEN)
                     |-> frm.readData[7] == carrierLvl
                         && frm.readData[1:0] == 2'h0)
    else $error("carrier bit or self-clear bits read wrong");

    AST_MUTE_WINS:
    assert property (!sleepNow && muteQ |=> outMuteQ && !eqBypassQ)
    else $error("mute did not override bypass");

    AST_BYPASS_SET:
    assert property (!sleepNow && !muteQ && bypassQ |=> eqBypassQ)
    else $error("bypass not applied");

    AST_SLEEP_WINS:
    assert property (eqSleepQ |-> !outMuteQ && !eqBypassQ)
    else $error("mute or bypass active in sleep");

    // power-down follows the code and carrier alone, the fsm is checked apart
    AST_SLEEP_CODES:
    assert property ((sleepQ == ceq_pkg::SLEEP_FORCE)
                     || (sleepQ == ceq_pkg::SLEEP_AUTO && !carrierLvl)
                     |=> eqSleepQ)
    else $error("sleep decode wrong");

    AST_AWAKE_CODES:
    assert property ((sleepQ == ceq_pkg::SLEEP_NEVER)
                     || (sleepQ == ceq_pkg::SLEEP_AUTO && carrierLvl)
                     || (sleepQ == 2'h3)
                     |=> !eqSleepQ)
    else $error("equalizer slept in an awake code");

    AST_FSM_SLEEPS:
    assert property (acqStateQ == ceq_pkg::ACQ_SLEEP |-> eqSleepQ)
    else $error("acquisition fsm asleep while powered");

    AST_MUTE_OFF:
    assert property (!muteQ |=> !outMuteQ)
    else $error("outputs muted while mute clear");

    AST_BYPASS_OFF:
    assert property (!bypassQ |=> !eqBypassQ)
    else $error("equalizer bypassed while bypass clear");

    AST_MASTER_DEFAULTS:
    assert property (masterRst |=> sleepQ == ceq_pkg::SLEEP_AUTO
                     && !muteQ && drvQ == ceq_pkg::DRV_RST
                     && launchQ == ceq_pkg::LAUNCH_RST && acqRestartQ)
    else $error("master reset did not restore defaults");

    AST_MASTER_ALL:
    assert property (masterRst |=> !bypassQ && !rsvQ && !eqLockQ)
    else $error("master reset left state behind");

    AST_RESTART_PULSE:
    assert property (acqRestartQ |=> !acqRestartQ)
    else $error("restart pulse longer than one cycle");

    AST_ACQ_RESTART:
    assert property (acqRst |=> acqRestartQ && !eqLockQ)
    else $error("acquisition reset did not restart search");

    AST_ACQ_ONLY:
    assert property (acqRst && !masterRst && !wrDrv
                     |=> acqStateQ == ceq_pkg::ACQ_SEEK && $stable(drvQ))
    else $error("acquisition reset misbehaved");

    AST_DRV_FIELDS:
    assert property (wrDrv && !masterRst
                     |=> outSwing == $past(frData[7:6])
                         && outOffset == $past(frData[5:4])
                         && deEmphLevel == $past(frData[2:1])
                         && drvQ[0] == 1'b0)
    else $error("driver fields not updated");

    AST_LAUNCH_BIT:
    assert property (wrLaunch |=> launchAtten == $past(frData[7]))
    else $error("launch setting not updated");

    // settings may only move on a completed frame
    AST_NO_STRAY_WRITE:
    assert property (!frm.frameValid |=> $stable(drvQ) && $stable(launchQ))
    else $error("setting changed without a frame");
endmodule

// ==== hw/ceq_frame_if.sv ====
interface ceq_frame_if;
    logic        frameValid;
    logic [15:0] frameWord;
    logic [7:0]  readData;

    modport spi (output frameValid, output frameWord, input readData);
    modport regs (input frameValid, input frameWord, output readData);
endinterface

// ==== hw/ceq_pkg.sv ====
// Behaviour
// - general control bit 7 reads carrier detect
// - mute bit 6 mutes outputs, beats bypass
// - bypass bit 5 bypasses the equalizer
// - sleep beats mute and bypass
// - sleep codes: on, auto, forced, reserved
// - master reset bit 1 restores all, self-clears
// - acquisition reset bit 0 restarts fsm, self-clears
// - driver bits 7:6 pick output swing
// - driver bits 5:4 pick common-mode level
// - driver bit 3 enables de-emphasis
// - driver bits 2:1 pick de-emphasis level
// - launch bit 7 selects 6 dB attenuation mode
// - frame: command bit, 7 address, 8 data
// - writes land only when select returns high
package ceq_pkg;
    // register offsets
    localparam logic [6:0] ADDR_GEN    = 7'h00;
    localparam logic [6:0] ADDR_DRV    = 7'h01;
    localparam logic [6:0] ADDR_LAUNCH = 7'h02;
    // general control fields
    localparam int GEN_CD_BIT   = 7;
    localparam int GEN_MUTE_BIT = 6;
    localparam int GEN_BYP_BIT  = 5;
    localparam int GEN_SLP_HI   = 4;
    localparam int GEN_SLP_LO   = 3;
    localparam int GEN_RSV_BIT  = 2;
    localparam int GEN_MRST_BIT = 1;
    localparam int GEN_ARST_BIT = 0;
    // output driver fields
    localparam int DRV_SWG_HI  = 7;
    localparam int DRV_SWG_LO  = 6;
    localparam int DRV_OFS_HI  = 5;
    localparam int DRV_OFS_LO  = 4;
    localparam int DRV_DEEN_BIT = 3;
    localparam int DRV_DLV_HI  = 2;
    localparam int DRV_DLV_LO  = 1;
    localparam logic [7:0] DRV_WR_MASK = 8'hfe;
    // launch amplitude fields
    localparam int LAUNCH_ATT_BIT = 7;
    // reset values
    localparam logic       MUTE_RST   = 1'b0;
    localparam logic       BYP_RST    = 1'b0;
    localparam logic [1:0] SLEEP_RST  = 2'h1;
    localparam logic       RSV_RST    = 1'b0;
    localparam logic [7:0] DRV_RST    = 8'ha2;
    localparam logic [7:0] LAUNCH_RST = 8'h68;
    // sleep field codes
    localparam logic [1:0] SLEEP_NEVER = 2'h0;
    localparam logic [1:0] SLEEP_AUTO  = 2'h1;
    localparam logic [1:0] SLEEP_FORCE = 2'h2;
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_BIT    = 15;
    localparam int ADDR_HI    = 14;
    localparam int ADDR_LO    = 8;
    localparam logic CMD_WRITE = 1'b0;
    localparam logic CMD_READ  = 1'b1;
    localparam logic [4:0] FRAME_FULL = 5'h10;

    typedef enum logic [1:0] {
        ACQ_SLEEP,
        ACQ_SEEK,
        ACQ_LOCK
    } ceq_acq_t;
endpackage

// ==== hw/ceq_spi_shift.sv ====
module ceq_spi_shift (
    // clock and reset
    input  wire logic    core_clk,
    input  wire logic    reset_n,
    // synchronised serial pins
    input  wire logic    sckLvl,
    input  wire logic    selNLvl,
    input  wire logic    mosiLvl,
    output logic         misoQ,
    // frame towards the register bank
    ceq_frame_if.spi     frm
);
    logic        sckPrevQ;
    logic        selNPrevQ;
    logic [15:0] shiftQ;
    logic [4:0]  bitCntQ;

    wire sckRise = sckLvl && !sckPrevQ && !selNLvl;
    wire sckFall = !sckLvl && sckPrevQ && !selNLvl;
    wire selRise = selNLvl && !selNPrevQ;
    wire cntFull = (bitCntQ == ceq_pkg::FRAME_FULL);
    wire rdLoad  = frm.frameValid
                   && (frm.frameWord[ceq_pkg::CMD_BIT] == ceq_pkg::CMD_READ);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sckPrevQ  <= 1'b0;
            selNPrevQ <= 1'b1;
        end else begin
            sckPrevQ  <= sckLvl;
            selNPrevQ <= selNLvl;
        end
    end

    // chains pass through: only the last sixteen bits form our frame
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftQ  <= 16'h0000;
            bitCntQ <= 5'h00;
        end else if (rdLoad) begin
            shiftQ  <= {frm.frameWord[15:8], frm.readData};
            bitCntQ <= 5'h00;
        end else if (selNLvl) begin
            bitCntQ <= 5'h00;
        end else if (sckRise) begin
            shiftQ  <= {shiftQ[14:0], mosiLvl};
            bitCntQ <= cntFull ? bitCntQ : bitCntQ + 5'h01;
        end
    end

    // short frames are dropped: a partial word must not write
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            frm.frameValid <= 1'b0;
            frm.frameWord  <= 16'h0000;
        end else begin
            frm.frameValid <= selRise && cntFull;
            if (selRise) begin
                frm.frameWord <= shiftQ;
            end
        end
    end

    // output changes on the falling clock, host samples on rising
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            misoQ <= 1'b0;
        end else if (selNLvl || sckFall) begin
            misoQ <= shiftQ[15];
        end
    end

    AST_FRAME_AT_DESELECT:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        frm.frameValid |-> selNLvl && $past(selRise))
    else $error("frame issued without select release");

    AST_READ_LOADS_SHIFT:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        rdLoad |=> shiftQ[7:0] == $past(frm.readData)
                   && shiftQ[15] == ceq_pkg::CMD_READ)
    else $error("read data not loaded into shifter");
endmodule

// ==== hw/ceq_sync3.sv ====
module ceq_sync3 #(
    parameter int         WIDTH   = 4,
    parameter logic [3:0] RST_VAL = 4'h0
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // asynchronous in, filtered out
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] stableOut
);
    logic [WIDTH-1:0] stage1Q;
    logic [WIDTH-1:0] stage2Q;
    logic [WIDTH-1:0] stage3Q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1Q <= RST_VAL[WIDTH-1:0];
            stage2Q <= RST_VAL[WIDTH-1:0];
            stage3Q <= RST_VAL[WIDTH-1:0];
        end else begin
            stage1Q <= asyncIn;
            stage2Q <= stage1Q;
            stage3Q <= stage2Q;
        end
    end

    // a bit only moves once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                stableOut[i] <= RST_VAL[i];
            end else if (stage2Q[i] == stage3Q[i]) begin
                stableOut[i] <= stage3Q[i];
            end
        end
    end
endmodule

// ==== verif/cable_eq_control_regs_tb.sv ====
module cable_eq_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk;
    logic       reset_n;
    logic       carrierDet;
    logic       spiSck;
    logic       spiSelN;
    logic       spiMosi;
    logic       spiMiso;
    logic       eqSleepQ;
    logic       outMuteQ;
    logic       eqBypassQ;
    logic       eqLockQ;
    logic       acqRestartQ;
    logic [1:0] outSwing;
    logic [1:0] outOffset;
    logic       deEmphEn;
    logic [1:0] deEmphLevel;
    logic       launchAtten;
    int         fails;
    int         cmpCount;
    int         pulses;
    int         expPulses;
    int         g;
    int         d;
    int         l;

    always #12.5 core_clk = ~core_clk;

    ceq_ctrl_regs dut (
        .core_clk(core_clk), .reset_n(reset_n), .spiSck(spiSck),
        .spiSelN(spiSelN), .spiMosi(spiMosi), .spiMiso(spiMiso),
        .carrierDet(carrierDet), .eqSleepQ(eqSleepQ),
        .outMuteQ(outMuteQ), .eqBypassQ(eqBypassQ), .eqLockQ(eqLockQ),
        .acqRestartQ(acqRestartQ), .outSwing(outSwing),
        .outOffset(outOffset), .deEmphEn(deEmphEn),
        .deEmphLevel(deEmphLevel), .launchAtten(launchAtten)
    );

    ceq_spi_host host (
        .core_clk(core_clk), .spiSck(spiSck), .spiSelN(spiSelN),
        .spiMosi(spiMosi), .spiMiso(spiMiso)
    );

    always @(posedge core_clk) begin
        if (acqRestartQ === 1'b1) pulses++;
    end

    task automatic complete_run;
        $display("fails=%0d cmpCount=%0d", fails, cmpCount);
        if (fails == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        cmpCount++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] regExp(input logic [6:0] a);
        case (a)
            ceq_pkg::ADDR_GEN:    return {carrierDet, 7'(g)};
            ceq_pkg::ADDR_DRV:    return 8'(d);
            ceq_pkg::ADDR_LAUNCH: return 8'(l);
            default:              return 8'h00;
        endcase
    endfunction

    // model follows each write once the frame has been taken
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [15:0] rx;
        host.xfer({ceq_pkg::CMD_WRITE, a, v}, 5 + $urandom % 4, rx);
        if (a == ceq_pkg::ADDR_GEN && v[1]) begin
            g = 8'h08;
            d = ceq_pkg::DRV_RST;
            l = ceq_pkg::LAUNCH_RST;
            expPulses++;
        end else if (a == ceq_pkg::ADDR_GEN) begin
            g = v & 8'h7c;
            expPulses += v[0];
        end else if (a == ceq_pkg::ADDR_DRV) begin
            d = v & ceq_pkg::DRV_WR_MASK;
        end else if (a == ceq_pkg::ADDR_LAUNCH) begin
            l = v;
        end
        host.waitN(12);
    endtask

    // second frame of all ones shifts the latched answer out
    task automatic rd(input logic [6:0] a);
        logic [15:0] rx;
        host.xfer({ceq_pkg::CMD_READ, a, 8'hff}, 6, rx);
        host.xfer(16'hffff, 9, rx);
        chk(rx, {1'b1, a, regExp(a)}, "read back");
        host.waitN(4);
    endtask

    task automatic chkOut;
        logic slp;
        logic mu;
        logic by;
        slp = (g[4:3] == 2'h2) || (g[4:3] == 2'h1 && !carrierDet);
        mu  = !slp && g[6];
        by  = !slp && !g[6] && g[5];
        chk(16'({eqSleepQ, outMuteQ, eqBypassQ, eqLockQ}),
            16'({slp, mu, by, carrierDet && !slp}), "control");
        chk(16'({outSwing, outOffset, deEmphEn, deEmphLevel, launchAtten}),
            16'({d[7:1], l[7]}), "driver");
        chk(16'(pulses), 16'(expPulses), "restart pulses");
    endtask

    initial begin
        core_clk   = 1'b0;
        reset_n    = 1'b0;
        fails      = 0;
        cmpCount   = 0;
        pulses     = 0;
        expPulses  = 0;
        g          = 8'h08;
        d          = ceq_pkg::DRV_RST;
        l          = ceq_pkg::LAUNCH_RST;
        void'($urandom(32'hce81));
        carrierDet = 1'($urandom % 2);
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        host.waitN(12);
        chkOut();
        for (int a = 0; a < 3; a++) rd(7'(a));
        // every sleep code, random mute, bypass and carrier
        for (int i = 0; i < 16; i++) begin
            carrierDet = 1'($urandom % 2);
            host.waitN(10);
            wr(ceq_pkg::ADDR_GEN, 8'(($urandom & 32'h60) | (i % 4) << 3));
            chkOut();
            rd(ceq_pkg::ADDR_GEN);
        end
        // every code of each driver field, bit 0 must stay 0
        for (int i = 0; i < 8; i++) begin
            wr(ceq_pkg::ADDR_DRV, {2'(i), 2'(i + 1), 1'(i >> 2),
                                   2'(i + 2), 1'(i)});
            chkOut();
            rd(ceq_pkg::ADDR_DRV);
        end
        wr(ceq_pkg::ADDR_LAUNCH, 8'he8);
        chkOut();
        rd(ceq_pkg::ADDR_LAUNCH);
        wr(ceq_pkg::ADDR_LAUNCH, 8'h68);
        chkOut();
        wr(ceq_pkg::ADDR_GEN, 8'h09);
        chkOut();
        rd(ceq_pkg::ADDR_GEN);
        // nothing may change while select is still low
        fork
            wr(ceq_pkg::ADDR_DRV, 8'h00);
            begin
                host.waitN(1);
                wait (host.bitCnt == 16);
                host.waitN(8);
                chk(16'(outSwing), 16'(d >> 6), "early write");
            end
        join
        wr(ceq_pkg::ADDR_LAUNCH, 8'he8);
        chkOut();
        // master reset wins over the rest of its own data
        wr(ceq_pkg::ADDR_GEN, 8'h62);
        chkOut();
        for (int a = 0; a < 3; a++) rd(7'(a));
        wr(7'h05, 8'h5a);
        rd(7'h05);
        chkOut();
        // a reset in mid-run must restore every default
        wr(ceq_pkg::ADDR_DRV, 8'h5c);
        wr(ceq_pkg::ADDR_GEN, 8'h70);
        chkOut();
        reset_n = 1'b0;
        host.waitN(3);
        reset_n = 1'b1;
        g = 8'h08;
        d = ceq_pkg::DRV_RST;
        l = ceq_pkg::LAUNCH_RST;
        host.waitN(12);
        chkOut();
        for (int a = 0; a < 3; a++) rd(7'(a));
        complete_run();
    end

    initial begin
        #1_250_000;
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end
endmodule

// ==== verif/ceq_spi_host.sv ====
module ceq_spi_host (
    // clock
    input  wire logic  core_clk,
    // serial pins towards the device
    output logic       spiSck,
    output logic       spiSelN,
    output logic       spiMosi,
    input  wire logic  spiMiso
);
    timeunit 1ns;
    timeprecision 1ps;

    int bitCnt;

    // mode 0: clock idles low and stands still between frames
    initial begin
        spiSck  = 1'b0;
        spiSelN = 1'b1;
        spiMosi = 1'b0;
        bitCnt  = 0;
    end

    task automatic waitN(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // half is core cycles per sck phase, 5 at the least
    task automatic xfer(input logic [15:0] tx, input int half,
                        output logic [15:0] rx);
        bitCnt  = 0;
        spiSelN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spiMosi = tx[i];
            waitN(half);
            rx[i]   = spiMiso;
            spiSck  = ~spiSck;
            bitCnt++;
            waitN(half);
            spiSck  = ~spiSck;
        end
        waitN(half);
        spiSelN = 1'b1;
        // a released line must not keep showing the last bit
        spiMosi = ~spiMosi;
        waitN(8);
    endtask
endmodule
